// ==== converter_config_status_regs.sv ====
`timescale 1ns/10ps
`include "conv_cfg_consts.svh"

module converter_config_status_regs
   import conv_cfg_pkg::*;
#(
   parameter logic [15:0] FUSE_LOAD_CYC =
      16'((`FUSE_LOAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
)
(
   // Clock and reset
   input  logic        clk,
   input  logic        rst_n,
   // Register port
   input  logic [11:0] addr,
   input  logic [7:0]  wdata,
   input  logic        wr,
   input  logic        rd,
   output logic [7:0]  rdata,
   // Events
   input  logic        sync_ref_in,
   input  logic        ovr_sample,
   // Status
   output logic        cfg_ready,
   output logic        sync_ref_detect_flag,
   output logic        ovr_out,
   output logic        irq,
   // Analog and power controls
   output logic        global_power_down,
   output logic        input_termination_select,
   // Output link controls
   output logic        lvds_term_100,
   output logic        half_swing,
   output logic        single_double_rate_select,
   output logic [15:0] lane_polarity_invert,
   output logic [7:0]  lane_power_down,
   output logic        data_clock_power_down
);

   regs_s q;
   regs_s n;
   logic  sync_evt;
   logic  clr_hit;
   logic  soft_rst;

   // Defaults shared by hardware reset and soft reset
   function automatic regs_s reset_val();
      regs_s r;
      r = '0;
      r.out_cfg = `OUT_CFG_RST;
      return r;
   endfunction

   // Upper inversion byte counts lanes downwards
   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = v[7 - i];
      end
      return r;
   endfunction

   function automatic logic [7:0] rd_byte(input regs_s s,
                                          input logic [11:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         `OFF_CFG_READY: r[`BIT_CFG_READY] = (s.fuse == FUSE_DONE);
         `OFF_SOFT_RST:  r = 8'h00;
         `OFF_GLB_PWR:   r[`BIT_GLB_PDN] = s.glb_pdn;
         `OFF_SYNC_CLR:  r[`BIT_SYNC_CLR] = s.sync_clr;
         `OFF_IN_TERM:   r[`BIT_IN_TERM] = s.in_term;
         `OFF_OVR_CTRL:  r = {5'h00, s.ovr_clr, s.ovr_sticky};
         `OFF_OVR_LEN:   r = s.ovr_len;
         `OFF_OUT_CFG:   r = s.out_cfg;
         `OFF_INV_LO:    r = s.inv_lo;
         `OFF_INV_HI:    r = s.inv_hi;
         `OFF_IRQ_STAT:  r = {5'h00, s.irq_st};
         `OFF_IRQ_MASK:  r = {5'h00, s.irq_mask};
         `OFF_SYNC_STAT: r[`BIT_SYNC_FLAG] = s.sync_flag;
         `OFF_PD_A:      r = {s.pd_a, 4'h0};
         `OFF_PD_B:      r = {3'h0, s.pd_b};
         default:        r = 8'h00;
      endcase
      return r;
   endfunction

   // Rising edge of the synchronised sync reference
   assign sync_evt = q.sr_sync & ~q.sr_prev;
   // Clear code acts for as long as it stays stored
   assign clr_hit  = (q.ovr_clr == `OVR_CLR_CODE);
   assign soft_rst = wr && (addr == `OFF_SOFT_RST) && wdata[`BIT_SOFT_RST];

   always_comb
   begin
      logic [2:0] ev;
      logic [2:0] rd_clr;
      regs_s      keep;
      ev     = 3'h0;
      rd_clr = 3'h0;
      keep   = '0;
      n      = q;

      // Pin synchroniser; only sr_sync and sr_prev are looked at
      n.sr_meta = sync_ref_in;
      n.sr_sync = q.sr_meta;
      n.sr_prev = q.sr_sync;

      // Fuse load sequencer
      // Counter parks once loaded, so ready never drops again
      case (q.fuse)
         FUSE_LOADING:
         begin
            if (q.fuse_cnt == FUSE_LOAD_CYC - 16'h0001)
            begin
               n.fuse = FUSE_DONE;
               ev[`IRQ_CFG] = 1'b1;
            end
            else
            begin
               n.fuse_cnt = q.fuse_cnt + 16'h0001;
            end
         end
         FUSE_DONE:
         begin
            n.fuse = FUSE_DONE;
         end
         default:
         begin
            n.fuse = FUSE_LOADING;
         end
      endcase

      // Register writes, reserved bits dropped
      if (wr)
      begin
         case (addr)
            `OFF_GLB_PWR:   n.glb_pdn = wdata[`BIT_GLB_PDN];
            `OFF_SYNC_CLR:  n.sync_clr = wdata[`BIT_SYNC_CLR];
            `OFF_IN_TERM:   n.in_term = wdata[`BIT_IN_TERM];
            `OFF_OVR_CTRL:
            begin
               n.ovr_clr    = wdata[2:1];
               n.ovr_sticky = wdata[`BIT_OVR_STICKY];
            end
            `OFF_OVR_LEN:   n.ovr_len = wdata;
            `OFF_OUT_CFG:   n.out_cfg = wdata & `OUT_CFG_MASK;
            `OFF_INV_LO:    n.inv_lo = wdata;
            `OFF_INV_HI:    n.inv_hi = wdata;
            `OFF_IRQ_MASK:  n.irq_mask = wdata[2:0];
            `OFF_PD_A:      n.pd_a = wdata[7:4];
            `OFF_PD_B:      n.pd_b = wdata[4:0];
            default:        n.glb_pdn = q.glb_pdn;
         endcase
      end

      // Flag set wins over the held clear
      n.sync_flag = sync_evt | (q.sync_flag & ~q.sync_clr);
      ev[`IRQ_SYNC] = sync_evt;

      // Overrange: sticky hold or retriggerable stretch
      if (q.ovr_sticky)
      begin
         n.ovr     = ovr_sample | (q.ovr & ~clr_hit);
         n.ovr_cnt = 8'h00;
      end
      else if (ovr_sample)
      begin
         n.ovr     = 1'b1;
         n.ovr_cnt = q.ovr_len;
      end
      else if (q.ovr_cnt != 8'h00)
      begin
         n.ovr     = 1'b1;
         n.ovr_cnt = q.ovr_cnt - 8'h01;
      end
      else
      begin
         n.ovr = 1'b0;
      end
      ev[`IRQ_OVR] = ovr_sample;

      // Status clears on read; a new event in that cycle survives
      if (rd && (addr == `OFF_IRQ_STAT))
      begin
         rd_clr = 3'h7;
      end
      n.irq_st = ev | (q.irq_st & ~rd_clr);

      n.rdata = rd ? rd_byte(q, addr) : 8'h00;

      // Soft reset keeps fuse state and synchroniser, rest to defaults
      if (soft_rst)
      begin
         keep       = n;
         n          = reset_val();
         n.fuse     = keep.fuse;
         n.fuse_cnt = keep.fuse_cnt;
         n.sr_meta  = keep.sr_meta;
         n.sr_sync  = keep.sr_sync;
         n.sr_prev  = keep.sr_prev;
      end

      n.irq = |(n.irq_st & n.irq_mask);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= reset_val();
      end
      else
      begin
         q <= n;
      end
   end

   assign rdata                     = q.rdata;
   assign cfg_ready                 = (q.fuse == FUSE_DONE);
   assign sync_ref_detect_flag      = q.sync_flag;
   assign ovr_out                   = q.ovr;
   assign irq                       = q.irq;
   assign global_power_down         = q.glb_pdn;
   assign input_termination_select  = q.in_term;
   assign lvds_term_100             = q.out_cfg[`BIT_OUT_TERM];
   assign half_swing                = q.out_cfg[`BIT_HALF_SWING];
   assign single_double_rate_select = q.out_cfg[`BIT_SDR];
   // Upper byte is wired in reverse lane order
   assign lane_polarity_invert      = {rev8(q.inv_hi), q.inv_lo};
   // Lanes 5..7 sit high in one byte, 0..4 reversed in the other
   assign lane_power_down = {q.pd_a[1], q.pd_a[2], q.pd_a[3],
                             q.pd_b[0], q.pd_b[1], q.pd_b[2],
                             q.pd_b[3], q.pd_b[4]};
   assign data_clock_power_down     = q.pd_a[0];

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_CFG_LOW: assert property (
      q.fuse_cnt < FUSE_LOAD_CYC - 16'h0001 && !cfg_ready |=> !cfg_ready)
      else $error("ready rose before fuse load end");

   AST_CFG_HOLD: assert property (
      cfg_ready |=> cfg_ready)
      else $error("ready bit dropped");

   AST_SOFT_RST: assert property (
      soft_rst |=> single_double_rate_select && !lvds_term_100
                   && lane_polarity_invert == 16'h0000 && !ovr_out)
      else $error("soft reset left non-default state");

   AST_SOFT_SELF: assert property (
      rd && addr == `OFF_SOFT_RST |=> rdata == 8'h00)
      else $error("soft reset bit not self-cleared");

   AST_SYNC_CLR: assert property (
      q.sync_clr && !sync_evt |=> !sync_ref_detect_flag)
      else $error("sync flag survived clear");

   AST_TERM: assert property (
      wr && addr == `OFF_IN_TERM && !soft_rst
      |=> input_termination_select == $past(wdata[0]))
      else $error("input termination not updated");

   AST_OVR_CLR: assert property (
      q.ovr_sticky && clr_hit && !ovr_sample |=> !ovr_out)
      else $error("sticky overrange not cleared");

   AST_OVR_STICKY: assert property (
      q.ovr_sticky && ovr_out && !clr_hit && !soft_rst |=> ovr_out)
      else $error("sticky overrange dropped");

   AST_OVR_WIDTH: assert property (
      (!q.ovr_sticky && ovr_sample && !wr && q.ovr_len == 8'h03
       ##1 (!ovr_sample && !wr)[*4])
      |-> ovr_out ##1 !ovr_out)
      else $error("overrange pulse width wrong");

   AST_OUT_CFG: assert property (
      wr && addr == `OFF_OUT_CFG
      |=> {lvds_term_100, half_swing, single_double_rate_select}
          == {$past(wdata[7]), $past(wdata[5]), $past(wdata[2])})
      else $error("output config not applied");

   AST_INV: assert property (
      wr && addr == `OFF_INV_HI |=> lane_polarity_invert[8] == $past(wdata[7]))
      else $error("lane 8 inversion misplaced");

   AST_PD: assert property (
      wr && addr == `OFF_PD_B |=> lane_power_down[0] == $past(wdata[4]))
      else $error("lane 0 power-down misplaced");

   AST_PD_A: assert property (
      wr && addr == `OFF_PD_A
      |=> lane_power_down[7:5] == {$past(wdata[5]), $past(wdata[6]), $past(wdata[7])})
      else $error("lanes 5 to 7 power-down misplaced");

   AST_INV_LO: assert property (
      wr && addr == `OFF_INV_LO |=> lane_polarity_invert[7:0] == $past(wdata))
      else $error("low lane inversion misplaced");

   // Ready bit as seen through the register port
   AST_CFG_RD: assert property (
      rd && addr == `OFF_CFG_READY
      |=> rdata[`BIT_CFG_READY] == $past(cfg_ready))
      else $error("ready bit read back wrong");

   AST_SOFT_CLEAR: assert property (
      soft_rst |=> !irq && !sync_ref_detect_flag && !global_power_down
                   && !input_termination_select && !half_swing
                   && !data_clock_power_down && lane_power_down == 8'h00)
      else $error("soft reset left flags or controls set");

   // Set wins over a stored clear
   AST_SYNC_SET: assert property (
      sync_evt && !soft_rst
      |=> sync_ref_detect_flag)
      else $error("sync flag missed an edge");

   AST_STICKY_SET: assert property (
      q.ovr_sticky && ovr_sample && !soft_rst
      |=> ovr_out)
      else $error("sticky overrange not set");

   AST_OVR_DROP: assert property (
      !q.ovr_sticky && q.ovr_cnt == 8'h00 && !ovr_sample
      |=> !ovr_out)
      else $error("non-sticky overrange did not drop");

   AST_OVR_SET: assert property (
      !q.ovr_sticky && ovr_sample && !soft_rst
      |=> ovr_out)
      else $error("overrange not raised by sample");

   AST_OVR_HOLD: assert property (
      !q.ovr_sticky && q.ovr_cnt != 8'h00 && !soft_rst
      |=> ovr_out)
      else $error("overrange dropped before stretch end");

   // Read data only stand in the cycle after the strobe
   AST_RDATA_IDLE: assert property (
      !rd |=> rdata == 8'h00)
      else $error("read data outside read cycle");

   AST_IRQ_SET: assert property (
      ovr_sample && q.irq_mask[`IRQ_OVR] && !wr
      |=> irq)
      else $error("unmasked event gave no interrupt");

   COV_READY: cover property ($rose(cfg_ready));
   COV_STICKY_CLR: cover property (q.ovr_sticky && ovr_out ##1 !ovr_out);
   COV_SOFT_RST: cover property (soft_rst);
   COV_IRQ: cover property ($rose(irq));
   COV_OVR_RETRIG: cover property (!q.ovr_sticky && ovr_sample && q.ovr_cnt != 8'h00);

endmodule

// ==== conv_cfg_consts.svh ====
`ifndef CONV_CFG_CONSTS_SVH
`define CONV_CFG_CONSTS_SVH

// Register offsets
`define OFF_CFG_READY  12'h025
`define OFF_SOFT_RST   12'h100
`define OFF_GLB_PWR    12'h101
`define OFF_SYNC_CLR   12'h102
`define OFF_IN_TERM    12'h104
`define OFF_OVR_CTRL   12'h10a
`define OFF_OVR_LEN    12'h10b
`define OFF_OUT_CFG    12'h110
`define OFF_INV_LO     12'h111
`define OFF_INV_HI     12'h112
`define OFF_IRQ_STAT   12'h120
`define OFF_IRQ_MASK   12'h121
`define OFF_SYNC_STAT  12'h140
`define OFF_PD_A       12'h691
`define OFF_PD_B       12'h692

// Field positions
`define BIT_CFG_READY  4
`define BIT_SOFT_RST   0
`define BIT_GLB_PDN    4
`define BIT_SYNC_CLR   6
`define BIT_SYNC_FLAG  6
`define BIT_IN_TERM    0
`define BIT_OVR_STICKY 0
`define BIT_OUT_TERM   7
`define BIT_HALF_SWING 5
`define BIT_SDR        2
`define BIT_DATA_CLOCK_POWER_DOWN    4
`define IRQ_CFG        0
`define IRQ_SYNC       1
`define IRQ_OVR        2
`define OVR_CLR_CODE   2'h2
`define OUT_CFG_MASK   8'ha4

// Reset values
`define OUT_CFG_RST    8'h04

// Timing
`define FUSE_LOAD_NS   320
`define CLK_PERIOD_NS  5

`endif

// ==== conv_cfg_pkg.sv ====
package conv_cfg_pkg;

   typedef enum logic [0:0]
   {
      FUSE_LOADING = 1'b0,
      FUSE_DONE    = 1'b1
   } fuse_e;

   typedef struct packed {
      fuse_e       fuse;
      logic [15:0] fuse_cnt;
      logic        sr_meta;
      logic        sr_sync;
      logic        sr_prev;
      logic        glb_pdn;
      logic        sync_clr;
      logic        sync_flag;
      logic        in_term;
      logic [1:0]  ovr_clr;
      logic        ovr_sticky;
      logic [7:0]  ovr_len;
      logic [7:0]  ovr_cnt;
      logic        ovr;
      logic [7:0]  out_cfg;
      logic [7:0]  inv_lo;
      logic [7:0]  inv_hi;
      logic [3:0]  pd_a;
      logic [4:0]  pd_b;
      logic [2:0]  irq_st;
      logic [2:0]  irq_mask;
      logic        irq;
      logic [7:0]  rdata;
   } regs_s;

endpackage

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   import conv_cfg_pkg::*;
   typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] r; int s; logic [15:0] o;} row_s;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        sync_ref_in = 1'b0;
   logic        ovr_sample = 1'b0;
   logic [7:0]  rdata;
   logic        cfg_ready, sync_ref_detect_flag, ovr_out, irq, global_power_down;
   logic        input_termination_select, lvds_term_100, half_swing, single_double_rate_select;
   logic [15:0] lane_polarity_invert;
   logic [7:0]  lane_power_down;
   logic        data_clock_power_down;
   logic [15:0] ov [8];
   int          fail_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          n;
   // Each row: write, read back, then one output
   row_s rows [13] = '{
      '{12'h101, 8'h10, 8'h10, 0, 16'h0001},
      '{12'h104, 8'h01, 8'h01, 1, 16'h0001},
      '{12'h110, 8'h80, 8'h80, 2, 16'h0001},
      '{12'h110, 8'h20, 8'h20, 3, 16'h0001},
      '{12'h110, 8'h00, 8'h00, 4, 16'h0000},
      '{12'h110, 8'hff, 8'ha4, 4, 16'h0001},
      '{12'h111, 8'h81, 8'h81, 5, 16'h0081},
      '{12'h112, 8'h01, 8'h01, 5, 16'h8081},
      '{12'h691, 8'hff, 8'hf0, 7, 16'h0001},
      '{12'h692, 8'h11, 8'h11, 6, 16'h00f1},
      '{12'h025, 8'hff, 8'h10, 0, 16'h0001},
      '{12'h3ff, 8'h55, 8'h00, 1, 16'h0001},
      '{12'h104, 8'h00, 8'h00, 1, 16'h0000}
   };

   assign ov[0] = {15'h0000, global_power_down};
   assign ov[1] = {15'h0000, input_termination_select};
   assign ov[2] = {15'h0000, lvds_term_100};
   assign ov[3] = {15'h0000, half_swing};
   assign ov[4] = {15'h0000, single_double_rate_select};
   assign ov[5] = lane_polarity_invert;
   assign ov[6] = {8'h00, lane_power_down};
   assign ov[7] = {15'h0000, data_clock_power_down};

   converter_config_status_regs #(.FUSE_LOAD_CYC(16'h0004)) converter_config_status_regs_i (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .sync_ref_in(sync_ref_in), .ovr_sample(ovr_sample), .cfg_ready(cfg_ready),
      .sync_ref_detect_flag(sync_ref_detect_flag), .ovr_out(ovr_out), .irq(irq),
      .global_power_down(global_power_down), .input_termination_select(input_termination_select),
      .lvds_term_100(lvds_term_100), .half_swing(half_swing),
      .single_double_rate_select(single_double_rate_select),
      .lane_polarity_invert(lane_polarity_invert), .lane_power_down(lane_power_down),
      .data_clock_power_down(data_clock_power_down));

   always #2.5 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e}, "rdata");
   endtask

   // Design samples the pulse at the second edge
   task automatic pulse();
      @(posedge clk);
      ovr_sample <= 1'b1;
      @(posedge clk);
      ovr_sample <= 1'b0;
   endtask

   task automatic count_ovr(input int cyc, input int e);
      n = 0;
      repeat (cyc)
      begin
         #1 if (ovr_out === 1'b1) n++;
         @(posedge clk);
      end
      chk(16'(n), 16'(e), "ovr width");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t timeout", $time);
         final_report();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk);
      chk(ov[4], 16'h0001, "sdr in reset");
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({15'h0, cfg_ready}, 16'h0000, "ready early");
      repeat (3) @(posedge clk);
      #1 chk({15'h0, cfg_ready}, 16'h0001, "ready late");
      rd_reg(12'h110, 8'h04);
      rd_reg(12'h025, 8'h10);
      rd_reg(12'h120, 8'h01);
      chk({15'h0, irq}, 16'h0000, "irq masked");
      wr_reg(12'h121, 8'h04);
      pulse();
      #1 chk({15'h0, irq}, 16'h0001, "irq set");
      rd_reg(12'h120, 8'h04);
      chk({15'h0, irq}, 16'h0000, "irq clear");
      wr_reg(12'h121, 8'h00);
      pulse();
      #1 chk({15'h0, irq}, 16'h0000, "irq masked");
      rd_reg(12'h120, 8'h04);
      foreach (rows[i])
      begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, rows[i].r);
         chk(ov[rows[i].s], rows[i].o, "output");
      end
      pulse();
      count_ovr(4, 1);
      wr_reg(12'h10b, 8'h03);
      pulse();
      count_ovr(7, 4);
      pulse();
      pulse();
      count_ovr(7, 4);
      wr_reg(12'h10a, 8'h01);
      pulse();
      count_ovr(10, 10);
      wr_reg(12'h10a, 8'h05);
      @(posedge clk);
      #1 chk({15'h0, ovr_out}, 16'h0000, "sticky clear");
      wr_reg(12'h10a, 8'h00);
      @(posedge clk) sync_ref_in <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk({15'h0, sync_ref_detect_flag}, 16'h0001, "sync flag");
      rd_reg(12'h140, 8'h40);
      wr_reg(12'h102, 8'h40);
      @(posedge clk);
      #1 chk({15'h0, sync_ref_detect_flag}, 16'h0000, "sync clear");
      rd_reg(12'h140, 8'h00);
      wr_reg(12'h102, 8'h00);
      wr_reg(12'h100, 8'h01);
      @(posedge clk);
      #1 chk(ov[0] | ov[2] | ov[5] | ov[6] | ov[7], 16'h0000, "soft reset");
      chk(ov[4], 16'h0001, "soft reset sdr");
      chk({15'h0, cfg_ready}, 16'h0001, "ready kept");
      rd_reg(12'h100, 8'h00);
      rd_reg(12'h110, 8'h04);
      @(posedge clk);
      #1 chk({8'h00, rdata}, 16'h0000, "rdata after read cycle");
      final_report();
   end
endmodule
